// ---- rtc_regs.svh ----
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register offsets on the internal 4-bit address
`define RTC_ADDR_SEC        4'h0
`define RTC_ADDR_MIN        4'h1
`define RTC_ADDR_HOUR       4'h2
`define RTC_ADDR_TRIM       4'h7
`define RTC_ADDR_CTRL1      4'hE
`define RTC_ADDR_CTRL2      4'hF

// control_one field positions
`define RTC_C1_FIRST_EN     7
`define RTC_C1_SECOND_EN    6
`define RTC_C1_ROUTE_HI     5
`define RTC_C1_ROUTE_LO     4
`define RTC_C1_CHIP_CHK     3
`define RTC_C1_CYCLE_MSB    2

// control_two field positions
`define RTC_C2_H24          5
`define RTC_C2_ROUND        4
`define RTC_C2_HALT         4
`define RTC_C2_CLOCK_OUT_DISABLE         3
`define RTC_C2_PFLAG        2
`define RTC_C2_AFLAG1       1
`define RTC_C2_AFLAG2       0

// Trim register field positions
`define RTC_TRIM_XSL        7
`define RTC_TRIM_SIGN       6

// Reset values
`define RTC_C1_RST          8'h00
`define RTC_TRIM_RST        8'h00
`define RTC_TIME_RST        8'h00

// Crystal rates and ticks per second
`define RTC_XTAL_HZ_STD     32768
`define RTC_XTAL_HZ_ALT     32000
`define RTC_SEC_TICKS_STD   16'h8000
`define RTC_SEC_TICKS_ALT   16'h7D00
// Pulse-mode phase marks in crystal ticks
`define RTC_HALF_STD        16'h4000
`define RTC_HALF_ALT        16'h3E00
`define RTC_QTR_STD         16'h2000
`define RTC_QTR_ALT         16'h1F00
`define RTC_QTR3_STD        16'h6000
`define RTC_QTR3_ALT        16'h5D80
// Lag of the falling edge behind the seconds increment
`define RTC_LAG_US_STD      92
`define RTC_LAG_US_ALT      94
`define RTC_LAG_TICKS_STD   ((`RTC_LAG_US_STD * `RTC_XTAL_HZ_STD) / 1000000)
`define RTC_LAG_TICKS_ALT   ((`RTC_LAG_US_ALT * `RTC_XTAL_HZ_ALT) / 1000000)
// Trim is applied once in this many seconds
`define RTC_TRIM_SECONDS    5'd20
// Reference cycles without a crystal edge before a halt is declared
`define RTC_HALT_TIMEOUT    16000

`endif

// ---- rtc_pkg.sv ----
package rtc_pkg;

   // Periodic interrupt cycle select, in field order
   typedef enum logic [2:0] {
      CYC_OFF,
      CYC_LOW,
      CYC_2HZ,
      CYC_1HZ,
      CYC_LVL_SEC,
      CYC_LVL_MIN,
      CYC_LVL_HOUR,
      CYC_LVL_MONTH
   } rtc_cycle_t;

   // Output routing select, in field order
   typedef enum logic [1:0] {
      ROUTE_ALL_A,
      ROUTE_B2_ON_B,
      ROUTE_INT_ON_B,
      ROUTE_A1_ONLY
   } rtc_route_t;

endpackage

// ---- rtc_time_count.sv ----
`timescale 1ns/1ps
`include "rtc_regs.svh"

module rtc_time_count
   import rtc_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Count controls
   input  wire logic       sec_tick_i,
   input  wire logic       round_i,
   input  wire logic       h24_i,
   // Register writes
   input  wire logic       wr_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   // Counter values
   output logic      [7:0] sec_o,
   output logic      [7:0] min_o,
   output logic      [7:0] hour_o
);

   logic [7:0] sec_r;
   logic [7:0] min_r;
   logic [7:0] hour_r;
   logic [7:0] sec_nxt;
   logic [7:0] min_nxt;
   logic [7:0] hour_nxt;

   // BCD digit-pair increment, used for every counter
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Next hour in either display system
   function automatic logic [7:0] hour_inc(input logic [7:0] h, input logic fmt24);
      if (fmt24) begin
         hour_inc = (h == 8'h23) ? 8'h00 : bcd_inc(h);
      end else begin
         case (h)
            8'h11:   hour_inc = 8'h32;
            8'h31:   hour_inc = 8'h12;
            8'h12:   hour_inc = 8'h01;
            8'h32:   hour_inc = 8'h21;
            default: hour_inc = bcd_inc(h);
         endcase
      end
   endfunction

   // Minute step with carry into the hour
   function automatic logic [15:0] min_step(input logic [7:0] m, input logic [7:0] h, input logic fmt24);
      if (m == 8'h59) begin
         min_step = {8'h00, hour_inc(h, fmt24)};
      end else begin
         min_step = {bcd_inc(m), h};
      end
   endfunction

   // Writes first, then the round command, then the regular count
   always_comb begin
      sec_nxt  = sec_r;
      min_nxt  = min_r;
      hour_nxt = hour_r;
      if (wr_i) begin
         if (addr_i == `RTC_ADDR_SEC) begin
            sec_nxt = {1'b0, wdata_i[6:0]};
         end
         if (addr_i == `RTC_ADDR_MIN) begin
            min_nxt = {1'b0, wdata_i[6:0]};
         end
         if (addr_i == `RTC_ADDR_HOUR) begin
            hour_nxt = {2'b00, wdata_i[5:0]};
         end
      end
      if (round_i) begin
         sec_nxt = 8'h00;
         if (sec_r >= 8'h30) begin
            {min_nxt, hour_nxt} = min_step(min_r, hour_r, h24_i);
         end
      end else if (sec_tick_i && !(wr_i && addr_i <= `RTC_ADDR_HOUR)) begin
         if (sec_r == 8'h59) begin
            sec_nxt = 8'h00;
            {min_nxt, hour_nxt} = min_step(min_r, hour_r, h24_i);
         end else begin
            sec_nxt = bcd_inc(sec_r);
         end
      end
   end

   // Counter registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sec_r  <= `RTC_TIME_RST;
         min_r  <= `RTC_TIME_RST;
         hour_r <= `RTC_TIME_RST;
      end else begin
         sec_r  <= sec_nxt;
         min_r  <= min_nxt;
         hour_r <= hour_nxt;
      end
   end

   assign sec_o  = sec_r;
   assign min_o  = min_r;
   assign hour_o = hour_r;

endmodule // rtc_time_count

// ---- rtc_irq_ctrl.sv ----
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Function
// - Route 00: alarms and periodic on A, clock on B; 01: second alarm moves to B.
// - Route 10: alarms on A, clock and periodic on B; 11: only first alarm on A.
// - Cycle 000 keeps periodic output released; 001 holds it low.
// - Cycle 010 gives 2 Hz square wave, 011 gives 1 Hz, both 50 percent.
// - Cycles 1xx are level mode: every second, minute, hour, month start.
// - Periodic falling edge follows the seconds increment by about 92 us, or 94 us for 32.000 kHz.
// - With 32.000 kHz crystal, pulses alternate 0.496 s and 0.504 s.
// - Trimming adjusts the periodic cycle once every 20 seconds, bounded shift.
// - Hour format bit selects 12-hour at zero, 24-hour at one.
// - 12-hour codes: AM 12,01-11; PM 32,21-31 with bit 5 as PM.
// - Round command at seconds 00-29 clears prescaler and seconds, minutes kept.
// - Round command at seconds 30-59 clears prescaler and seconds, minute plus one.
// - Round adjustment completes within 122 us, or 125 us for 32.000 kHz.
// - Round command bit is write-only; its position reads the halt flag.
// - Halt flag sets when oscillation stops and stays set after restart.
// - While halted, crystal select, trim, cycle, enables, route, clock disable, chip-check clear.
// - While halted, output A drives nothing and output B carries the crystal clock.
// - Any write to control_two while oscillating clears the halt flag.
// - control_two bits 7 and 6 read zero; after halt flags and disable read zero.
// - In level mode software may only clear the periodic flag, releasing output.
// - Alarm flags only clear by software writing zero; disabled alarm reads zero.
// - Alarm enable one lets its match raise the event; zero suppresses it.
module rtc_irq_ctrl
   import rtc_pkg::*;
#(
   parameter int HALT_TIMEOUT = `RTC_HALT_TIMEOUT
)(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Register port
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Crystal and event inputs
   input  wire logic       xtal_clk_i,
   input  wire logic       alarm_first_match_i,
   input  wire logic       alarm_second_match_i,
   input  wire logic       month_first_day_i,
   // Open-drain interrupt pins
   output logic            irq_out_first_o,
   output logic            irq_out_first_oe_n_o,
   output logic            irq_out_second_o,
   output logic            irq_out_second_oe_n_o
);

   localparam int WD_W = $clog2(HALT_TIMEOUT + 1);

   // Prescaler and trim state
   logic [15:0]     presc_r, presc_nxt;
   logic [15:0]     limit_r, limit_nxt;
   logic [4:0]      trim_cnt_r, trim_cnt_nxt;
   logic            xtal_q_r;
   // Halt sensing state
   logic [WD_W-1:0] wd_r, wd_nxt;
   logic            osc_stop_r, osc_stop_nxt;
   logic            halt_r, halt_nxt;
   // Control and flag registers
   logic [7:0]      ctrl1_r, ctrl1_nxt;
   logic [7:0]      trim_r, trim_nxt;
   logic            h24_r, h24_nxt;
   logic            clock_out_disable_r, clock_out_disable_nxt;
   logic            pflag_r, pflag_nxt;
   logic            aflag1_r, aflag1_nxt;
   logic            aflag2_r, aflag2_nxt;
   // Read data and pin registers
   logic [7:0]      rdata_r, rdata_nxt;
   logic            low_a_r, low_a_nxt;
   logic            low_b_r, low_b_nxt;

   logic            xtick, sec_tick, round_cmd, wr_c2, lag_hit, lvl_evt, int_active, std_xtal;
   logic [15:0]     half_m, qtr_m, qtr3_m, lag_m, sec_full;
   logic [7:0]      sec_v, min_v, hour_v, c2_read;
   logic [5:0]      trim_mag;
   rtc_cycle_t      cycle;
   rtc_route_t      route;

   // Crystal edge, a one-cycle enable at the crystal rate
   assign xtick     = xtal_clk_i & ~xtal_q_r;
   assign wr_c2     = reg_wr_i && (reg_addr_i == `RTC_ADDR_CTRL2);
   assign round_cmd = wr_c2 && reg_wdata_i[`RTC_C2_ROUND];
   assign cycle     = rtc_cycle_t'(ctrl1_r[`RTC_C1_CYCLE_MSB:0]);
   assign route     = rtc_route_t'({ctrl1_r[`RTC_C1_ROUTE_HI], ctrl1_r[`RTC_C1_ROUTE_LO]});

   // Phase marks follow the crystal select
   assign std_xtal = ~trim_r[`RTC_TRIM_XSL];
   assign sec_full = std_xtal ? `RTC_SEC_TICKS_STD : `RTC_SEC_TICKS_ALT;
   assign half_m   = std_xtal ? `RTC_HALF_STD : `RTC_HALF_ALT;
   assign qtr_m    = std_xtal ? `RTC_QTR_STD : `RTC_QTR_ALT;
   assign qtr3_m   = std_xtal ? `RTC_QTR3_STD : `RTC_QTR3_ALT;
   assign lag_m    = std_xtal ? 16'(`RTC_LAG_TICKS_STD) : 16'(`RTC_LAG_TICKS_ALT);
   assign sec_tick = xtick && (presc_r == limit_r - 16'h0001);
   assign trim_mag = trim_r[5:0];

   // Seconds, minutes and hours live in their own counter
   rtc_time_count u_time (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .sec_tick_i (sec_tick),
      .round_i    (round_cmd),
      .h24_i      (h24_r),
      .wr_i       (reg_wr_i),
      .addr_i     (reg_addr_i),
      .wdata_i    (reg_wdata_i),
      .sec_o      (sec_v),
      .min_o      (min_v),
      .hour_o     (hour_v)
   );

   // Second period with trim; only every twentieth second is stretched or cut
   always_comb begin
      presc_nxt    = presc_r;
      limit_nxt    = limit_r;
      trim_cnt_nxt = trim_cnt_r;
      if (round_cmd) begin
         presc_nxt = 16'h0000;
         limit_nxt = sec_full;
      end else if (sec_tick) begin
         presc_nxt    = 16'h0000;
         limit_nxt    = sec_full;
         trim_cnt_nxt = (trim_cnt_r == `RTC_TRIM_SECONDS - 5'd1) ? 5'd0 : trim_cnt_r + 5'd1;
         if (trim_cnt_r == `RTC_TRIM_SECONDS - 5'd1 && trim_mag > 6'h01) begin
            if (trim_r[`RTC_TRIM_SIGN]) begin
               limit_nxt = sec_full + {9'h000, 6'h3F - trim_mag, 1'b0};
            end else begin
               limit_nxt = sec_full - {9'h000, trim_mag - 6'h01, 1'b0};
            end
         end
      end else if (xtick) begin
         presc_nxt = presc_r + 16'h0001;
      end
   end

   // Periodic wave: low phase starts a few ticks after the second increments
   always_comb begin
      lag_hit = xtick && (presc_r == lag_m - 16'h0001);
      case (cycle)
         CYC_LVL_SEC:   lvl_evt = lag_hit;
         CYC_LVL_MIN:   lvl_evt = lag_hit && sec_v == 8'h00;
         CYC_LVL_HOUR:  lvl_evt = lag_hit && sec_v == 8'h00 && min_v == 8'h00;
         CYC_LVL_MONTH: lvl_evt = lag_hit && sec_v == 8'h00 && min_v == 8'h00 && month_first_day_i
                                  && hour_v == (h24_r ? 8'h00 : 8'h12);
         default:       lvl_evt = 1'b0;
      endcase
      case (cycle)
         CYC_OFF:  int_active = 1'b0;
         CYC_LOW:  int_active = 1'b1;
         CYC_2HZ:  int_active = (presc_r >= lag_m && presc_r < qtr_m + lag_m)
                                || (presc_r >= half_m + lag_m && presc_r < qtr3_m + lag_m);
         CYC_1HZ:  int_active = presc_r >= lag_m && presc_r < half_m + lag_m;
         default:  int_active = pflag_r;
      endcase
   end

   // Halt sensing: a watchdog on the crystal edges
   always_comb begin
      osc_stop_nxt = osc_stop_r;
      wd_nxt       = wd_r;
      if (xtick) begin
         wd_nxt       = '0;
         osc_stop_nxt = 1'b0;
      end else if (wd_r == WD_W'(HALT_TIMEOUT)) begin
         osc_stop_nxt = 1'b1;
      end else begin
         wd_nxt = wd_r + WD_W'(1);
      end
      halt_nxt = halt_r;
      if (wr_c2 && !osc_stop_r) begin
         halt_nxt = 1'b0;
      end
      if (osc_stop_r) begin
         halt_nxt = 1'b1;
      end
   end

   // Control registers and flags; hardware set wins over a software clear
   always_comb begin
      ctrl1_nxt  = ctrl1_r;
      trim_nxt   = trim_r;
      h24_nxt    = h24_r;
      clock_out_disable_nxt   = clock_out_disable_r;
      pflag_nxt  = pflag_r;
      aflag1_nxt = aflag1_r;
      aflag2_nxt = aflag2_r;
      if (reg_wr_i && reg_addr_i == `RTC_ADDR_CTRL1) begin
         ctrl1_nxt = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `RTC_ADDR_TRIM) begin
         trim_nxt = reg_wdata_i;
      end
      if (wr_c2) begin
         h24_nxt  = reg_wdata_i[`RTC_C2_H24];
         clock_out_disable_nxt = reg_wdata_i[`RTC_C2_CLOCK_OUT_DISABLE];
         if (!reg_wdata_i[`RTC_C2_PFLAG]) begin
            pflag_nxt = 1'b0;
         end
         if (!reg_wdata_i[`RTC_C2_AFLAG1]) begin
            aflag1_nxt = 1'b0;
         end
         if (!reg_wdata_i[`RTC_C2_AFLAG2]) begin
            aflag2_nxt = 1'b0;
         end
      end
      if (lvl_evt) begin
         pflag_nxt = 1'b1;
      end
      if (cycle < CYC_LVL_SEC) begin
         pflag_nxt = 1'b0;
      end
      if (alarm_first_match_i) begin
         aflag1_nxt = 1'b1;
      end
      if (alarm_second_match_i) begin
         aflag2_nxt = 1'b1;
      end
      // Disabled alarms hold their flags at zero
      if (!ctrl1_r[`RTC_C1_FIRST_EN]) begin
         aflag1_nxt = 1'b0;
      end
      if (!ctrl1_r[`RTC_C1_SECOND_EN]) begin
         aflag2_nxt = 1'b0;
      end
      if (halt_r) begin
         ctrl1_nxt = `RTC_C1_RST;
         trim_nxt  = `RTC_TRIM_RST;
         clock_out_disable_nxt  = 1'b0;
      end
   end

   // Pin sources: routing, sharing, and the forced halt behaviour
   always_comb begin
      low_a_nxt = aflag1_r;
      low_b_nxt = ~clock_out_disable_r & ~xtal_clk_i;
      case (route)
         ROUTE_ALL_A: begin
            low_a_nxt = aflag1_r | aflag2_r | int_active;
         end
         ROUTE_B2_ON_B: begin
            low_a_nxt = aflag1_r | int_active;
            low_b_nxt = low_b_nxt | aflag2_r;
         end
         ROUTE_INT_ON_B: begin
            low_a_nxt = aflag1_r | aflag2_r;
            low_b_nxt = low_b_nxt | int_active;
         end
         ROUTE_A1_ONLY: begin
            low_b_nxt = low_b_nxt | aflag2_r | int_active;
         end
         default: begin
            low_a_nxt = 1'b0;
         end
      endcase
      if (halt_r) begin
         low_a_nxt = 1'b0;
         low_b_nxt = ~xtal_clk_i;
      end
   end

   // Read data; the round command position shows the halt flag
   always_comb begin
      c2_read = 8'h00;
      c2_read[`RTC_C2_H24]    = h24_r;
      c2_read[`RTC_C2_HALT]   = halt_r;
      c2_read[`RTC_C2_CLOCK_OUT_DISABLE]   = clock_out_disable_r;
      c2_read[`RTC_C2_PFLAG]  = (cycle >= CYC_LVL_SEC) ? pflag_r : int_active;
      c2_read[`RTC_C2_AFLAG1] = aflag1_r;
      c2_read[`RTC_C2_AFLAG2] = aflag2_r;
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `RTC_ADDR_SEC:   rdata_nxt = sec_v;
            `RTC_ADDR_MIN:   rdata_nxt = min_v;
            `RTC_ADDR_HOUR:  rdata_nxt = hour_v;
            `RTC_ADDR_TRIM:  rdata_nxt = trim_r;
            `RTC_ADDR_CTRL1: rdata_nxt = ctrl1_r;
            `RTC_ADDR_CTRL2: rdata_nxt = c2_read;
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   // State registers; reset comes up as after a power-on from zero volts
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         presc_r    <= 16'h0000;
         limit_r    <= `RTC_SEC_TICKS_STD;
         trim_cnt_r <= 5'd0;
         xtal_q_r   <= 1'b0;
         wd_r       <= '0;
         osc_stop_r <= 1'b0;
         halt_r     <= 1'b1;
         ctrl1_r    <= `RTC_C1_RST;
         trim_r     <= `RTC_TRIM_RST;
         h24_r      <= 1'b0;
         clock_out_disable_r     <= 1'b0;
         pflag_r    <= 1'b0;
         aflag1_r   <= 1'b0;
         aflag2_r   <= 1'b0;
         rdata_r    <= 8'h00;
         low_a_r    <= 1'b0;
         low_b_r    <= 1'b0;
      end else begin
         presc_r    <= presc_nxt;
         limit_r    <= limit_nxt;
         trim_cnt_r <= trim_cnt_nxt;
         xtal_q_r   <= xtal_clk_i;
         wd_r       <= wd_nxt;
         osc_stop_r <= osc_stop_nxt;
         halt_r     <= halt_nxt;
         ctrl1_r    <= ctrl1_nxt;
         trim_r     <= trim_nxt;
         h24_r      <= h24_nxt;
         clock_out_disable_r     <= clock_out_disable_nxt;
         pflag_r    <= pflag_nxt;
         aflag1_r   <= aflag1_nxt;
         aflag2_r   <= aflag2_nxt;
         rdata_r    <= rdata_nxt;
         low_a_r    <= low_a_nxt;
         low_b_r    <= low_b_nxt;
      end
   end

   // Open-drain pins: data is always low, the enable does the work
   assign reg_rdata_o           = rdata_r;
   assign irq_out_first_o       = 1'b0;
   assign irq_out_first_oe_n_o  = ~low_a_r;
   assign irq_out_second_o      = 1'b0;
   assign irq_out_second_oe_n_o = ~low_b_r;

endmodule // rtc_irq_ctrl

// ---- rtc_irq_monitor.sv ----
`timescale 1ns/1ps
module rtc_irq_monitor #(
   parameter int HALT_TIMEOUT = 40
)(
   // Clock, reset and register port
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Crystal and pins
   input wire logic       xtal_clk_i,
   input wire logic       irq_out_first_o,
   input wire logic       irq_out_first_oe_n_o,
   input wire logic       irq_out_second_o,
   input wire logic       irq_out_second_oe_n_o
);
   logic wr2_r;
   logic wr2_nxt;
   // Halt must stand until the first control_two write
   always_comb begin
      wr2_nxt = wr2_r | (reg_wr_i && reg_addr_i == 4'hF);
      if (rst_i) begin
         wr2_nxt = 1'b0;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      wr2_r <= wr2_nxt;
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_pin_data;
      irq_out_first_o == 1'b0 && irq_out_second_o == 1'b0;
   endproperty
   a_pin_data: assert property (p_pin_data) else $error("pin data not low");
   property p_top_zero;
      reg_rd_i && reg_addr_i == 4'hF |=> reg_rdata_o[7:6] == 2'b00;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("ctrl2 top bits set");
   // Own disable: the reset itself is the cause here
   property p_reset_pins;
      @(posedge ref_clk_i) disable iff (1'b0)
      rst_i |=> irq_out_first_oe_n_o && irq_out_second_oe_n_o;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins not released");
   property p_halt_ctrl2;
      reg_rd_i && reg_addr_i == 4'hF && !wr2_r && !reg_wr_i |=> reg_rdata_o[4:0] == 5'h10;
   endproperty
   a_halt_ctrl2: assert property (p_halt_ctrl2) else $error("halted ctrl2 wrong");
   property p_halt_ctrl1;
      reg_rd_i && reg_addr_i == 4'hE && !wr2_r |=> reg_rdata_o == 8'h00;
   endproperty
   a_halt_ctrl1: assert property (p_halt_ctrl1) else $error("halted ctrl1 not zero");
   property p_halt_pin_a;
      !wr2_r |-> irq_out_first_oe_n_o;
   endproperty
   a_halt_pin_a: assert property (p_halt_pin_a) else $error("pin A driven in halt");
   // Pin B may only move shortly after a crystal edge
   property p_halt_pin_b;
      !wr2_r && !$past(rst_i) && $changed(irq_out_second_oe_n_o)
      |-> ($past(xtal_clk_i) != $past(xtal_clk_i, 2)) || ($past(xtal_clk_i, 2) != $past(xtal_clk_i, 3));
   endproperty
   a_halt_pin_b: assert property (p_halt_pin_b) else $error("pin B not crystal");
   property p_round;
      (reg_wr_i && reg_addr_i == 4'hF && reg_wdata_i[4]) ##2 (reg_rd_i && reg_addr_i == 4'h0 && !reg_wr_i)
      |=> reg_rdata_o == 8'h00;
   endproperty
   a_round: assert property (p_round) else $error("seconds not rounded");
endmodule // rtc_irq_monitor

// ---- rtc_host_model.sv ----
`timescale 1ns/1ps
module rtc_host_model (
   // Clock and crystal control
   input  wire logic ref_clk_i,
   input  wire logic run_i,
   // Pin drive from the device
   input  wire logic a_data_i,
   input  wire logic a_oe_n_i,
   input  wire logic b_data_i,
   input  wire logic b_oe_n_i,
   // Crystal and resolved pins
   output logic      xtal_o,
   output logic      pin_a_o,
   output logic      pin_b_o
);
   logic [1:0] ph_r = 2'h0;
   // Crystal stands still while stopped, like a dead oscillator
   always_ff @(posedge ref_clk_i) begin
      if (run_i) begin
         ph_r <= ph_r + 2'h1;
      end
   end
   assign xtal_o = ph_r[1];
   // Pull-ups: a released pin reads high
   assign pin_a_o = a_oe_n_i ? 1'b1 : a_data_i;
   assign pin_b_o = b_oe_n_i ? 1'b1 : b_data_i;
endmodule // rtc_host_model

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
   localparam int HALT_CYC = 40;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       run = 1'b1;
   logic       m1 = 1'b0;
   logic       m2 = 1'b0;
   logic [7:0] rdata, val;
   logic       xtal, a_d, a_oe_n, b_d, b_oe_n, pin_a, pin_b;
   int         err_total = 0;
   int         num_checks = 0;
   int         cyc = 0;
   int         cnt;
   // Rows: ctrl1, {m1, m2, pin A, pin B}, expected ctrl2
   logic [19:0] rows [12] = '{20'h0112C, 20'h1112C, 20'h2122C, 20'h3122C, 20'h00328, 20'hC0D2B,
                              20'hD0C2B, 20'hE0D2B, 20'hF0C2B, 20'h40529, 20'h70629, 20'h30F28};
   rtc_irq_ctrl #(.HALT_TIMEOUT(HALT_CYC)) u_rtc_irq_ctrl (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .xtal_clk_i(xtal), .alarm_first_match_i(m1),
      .alarm_second_match_i(m2), .month_first_day_i(1'b0), .irq_out_first_o(a_d),
      .irq_out_first_oe_n_o(a_oe_n), .irq_out_second_o(b_d), .irq_out_second_oe_n_o(b_oe_n));
   rtc_host_model u_rtc_host_model (
      .ref_clk_i(ref_clk_i), .run_i(run), .a_data_i(a_d), .a_oe_n_i(a_oe_n), .b_data_i(b_d),
      .b_oe_n_i(b_oe_n), .xtal_o(xtal), .pin_a_o(pin_a), .pin_b_o(pin_b));
   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Strobes drop one edge before the next request
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      @(posedge ref_clk_i);
      #1 d = rdata;
   endtask
   task automatic pulse(input logic a, input logic b);
      @(posedge ref_clk_i);
      m1 <= a;
      m2 <= b;
      @(posedge ref_clk_i);
      m1 <= 1'b0;
      m2 <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wreg(4'hE, 8'h21);
      rreg(4'hE, val);
      `CHK(val, 8'h00)
      rreg(4'hF, val);
      `CHK(val & 8'hDF, 8'h10)
      cnt = 0;
      repeat (32) begin
         @(posedge ref_clk_i);
         #1 cnt += int'(pin_b === 1'b0);
      end
      `CHK(cnt >= 12 && cnt <= 20, 1'b1)
      `CHK(pin_a, 1'b1)
      wreg(4'hF, 8'h20); // Hour format before any time write
      wreg(4'hF, 8'h28);
      rreg(4'hF, val);
      `CHK(val, 8'h28)
      foreach (rows[i]) begin
         wreg(4'hE, rows[i][19:12]); // Test bit always clear
         pulse(rows[i][11], rows[i][10]);
         `CHK({pin_a, pin_b}, rows[i][9:8])
         rreg(4'hF, val);
         `CHK(val, rows[i][7:0])
         wreg(4'hF, 8'h28);
      end
      // Two alarms share pin A; dropping one must not release it
      wreg(4'hE, 8'hC0);
      pulse(1'b1, 1'b1);
      wreg(4'hF, 8'h29);
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK(pin_a, 1'b0)
      wreg(4'hF, 8'h28);
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK(pin_a, 1'b1)
      wreg(4'h1, 8'h10);
      for (int i = 0; i < 2; i++) begin
         wreg(4'h0, (i == 0) ? 8'h29 : 8'h30);
         wreg(4'hF, 8'h38);
         rreg(4'h0, val);
         `CHK(val, 8'h00)
         rreg(4'h1, val);
         `CHK(val, 8'h10 + 8'(i))
      end
      rreg(4'hF, val);
      `CHK(val, 8'h28)
      rreg(4'h8, val);
      `CHK(val, 8'h00) // Unmapped place reads zero
      // A 30 s round carries through minute 59 into the hour
      wreg(4'h2, 8'h23);
      wreg(4'h1, 8'h59);
      wreg(4'h0, 8'h45);
      wreg(4'hF, 8'h38);
      rreg(4'h2, val);
      `CHK(val, 8'h00)
      wreg(4'hF, 8'h08); // Format first, then time
      wreg(4'h2, 8'h11);
      wreg(4'h1, 8'h59);
      wreg(4'h0, 8'h30);
      wreg(4'hF, 8'h18);
      rreg(4'h2, val);
      `CHK(val, 8'h32)
      // 1 Hz: the round restarts the phase, low follows a few ticks later
      wreg(4'hE, 8'h03);
      wreg(4'hF, 8'h18);
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK(pin_a, 1'b1)
      repeat (20) @(posedge ref_clk_i);
      #1 `CHK(pin_a, 1'b0)
      // Level mode: set by the tick, kept by a one, cleared by a zero
      wreg(4'hE, 8'h04);
      wreg(4'hF, 8'h1C);
      repeat (20) @(posedge ref_clk_i);
      wreg(4'hF, 8'h0C);
      rreg(4'hF, val);
      `CHK(val, 8'h0C)
      `CHK(pin_a, 1'b0)
      wreg(4'hF, 8'h08);
      repeat (2) @(posedge ref_clk_i);
      #1 `CHK(pin_a, 1'b1)
      // Stop the crystal with pin A pulled low by the periodic source
      wreg(4'hE, 8'h01);
      run <= 1'b0;
      repeat (HALT_CYC + 20) @(posedge ref_clk_i);
      wreg(4'hF, 8'h28);
      rreg(4'hF, val);
      `CHK(val & 8'hDF, 8'h10)
      rreg(4'hE, val);
      `CHK(val, 8'h00)
      `CHK(pin_a, 1'b1)
      run <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      wreg(4'hF, 8'h20);
      rreg(4'hF, val);
      `CHK(val, 8'h20)
      conclude();
   end
endmodule // testbench
bind rtc_irq_ctrl rtc_irq_monitor #(.HALT_TIMEOUT(HALT_TIMEOUT)) u_rtc_irq_monitor (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .xtal_clk_i(xtal_clk_i), .irq_out_first_o(irq_out_first_o), .irq_out_first_oe_n_o(irq_out_first_oe_n_o),
   .irq_out_second_o(irq_out_second_o), .irq_out_second_oe_n_o(irq_out_second_oe_n_o));
